// file: rxsw_pkg.sv
// receive status word constants and the frame header parser
`timescale 1ns/1ns
package rxsw_pkg;
    // status word field positions
    localparam int BIT_RSVD31 = 31;
    localparam int BIT_FILTER_FAIL = 30;
    localparam int LEN_LSB = 16;
    localparam int LEN_W = 14;
    localparam int BIT_ERR_SUM = 15;
    localparam int BIT_RSVD14 = 14;
    localparam int BIT_BCAST = 13;
    localparam int BIT_LEN_MISMATCH = 12;
    localparam int BIT_RUNT = 11;
    localparam int BIT_MCAST = 10;
    localparam int BIT_TOO_LONG = 7;
    localparam int BIT_LATE_COL = 6;
    localparam int BIT_FRAME_TYPE = 5;
    localparam int BIT_WDOG = 4;
    localparam int BIT_MII_ERR = 3;
    localparam int BIT_DRIBBLE = 2;
    localparam int BIT_CRC_ERR = 1;
    localparam int BIT_RSVD0 = 0;
    // frame sizes in bytes
    localparam logic [13:0] MIN_FRAME = 14'h0040;
    localparam logic [13:0] MAX_FRAME = 14'h05ee;
    localparam logic [15:0] MAX_LEN_FIELD = 16'h05dc;
    localparam logic [13:0] HDR_BYTES = 14'h000e;
    localparam logic [13:0] OVERHEAD_BYTES = 14'h0012;
    localparam logic [15:0] MIN_PAYLOAD = 16'h002e;
    localparam int WDOG_MIN = 2048;
    localparam int WDOG_MAX = 2560;
    // dribble thresholds per mode
    localparam logic [2:0] DRIB_MII = 3'h4;
    localparam logic [2:0] DRIB_10M = 3'h3;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // payload implied by the byte count against the length field; type values never mismatch
    function automatic logic lenMismatch(input logic [15:0] field, input logic [13:0] total);
        logic [15:0] payload;
        payload = {2'b00, total - OVERHEAD_BYTES};
        if (field > MAX_LEN_FIELD || total < HDR_BYTES + 14'h0004)
        begin
            return 1'b0;
        end
        // short payloads are padded up to the minimum on the wire
        if (field < MIN_PAYLOAD)
        begin
            return payload != MIN_PAYLOAD;
        end
        return payload != field;
    endfunction : lenMismatch
endpackage : rxsw_pkg

module rxsw_hdr_parse
    import rxsw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic frameStart,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    output logic dstBroadcast,
    output logic dstMulticast,
    output logic [15:0] lenType
);
    logic [3:0] idx_q;
    logic allOnes_q;
    logic groupBit_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            idx_q <= 4'h0;
            allOnes_q <= 1'b1;
            groupBit_q <= 1'b0;
            lenType <= 16'h0000;
        end
        else if (frameStart)
        begin
            idx_q <= 4'h0;
            allOnes_q <= 1'b1;
            groupBit_q <= 1'b0;
            lenType <= 16'h0000;
        end
        else if (byteValid && idx_q < 4'he)
        begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == 4'h0)
            begin
                groupBit_q <= byteData[0];
            end
            if (idx_q < 4'h6 && byteData != 8'hff)
            begin
                allOnes_q <= 1'b0;
            end
            if (idx_q == 4'hc)
            begin
                lenType[15:8] <= byteData;
            end
            if (idx_q == 4'hd)
            begin
                lenType[7:0] <= byteData;
            end
        end
    end

    // a broadcast also carries the group bit, so it is kept out of multicast
    assign dstBroadcast = allOnes_q && idx_q >= 4'h6;
    assign dstMulticast = groupBit_q && !dstBroadcast && idx_q >= 4'h6;
endmodule : rxsw_hdr_parse

// file: rxsw_rx_status.sv
// receive status word builder, receiver halt control and receive fault flag
`timescale 1ns/1ns
module rxsw_rx_status
    import rxsw_pkg::*;
#(
    parameter int WDOG_BYTES = WDOG_MIN
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic receive_enable_bit,
    input wire logic passBadFrames,
    input wire logic speed10,
    input wire logic frmStart,
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    input wire logic frmEnd,
    input wire logic crcBad,
    input wire logic [2:0] dribbleBits,
    input wire logic rxEr,
    input wire logic lateCollision,
    input wire logic filterFail,
    input wire logic hostDataRead,
    input wire logic dataFifoEmpty,
    input wire logic hostStatusRead,
    input wire logic statusFifoEmpty,
    input wire logic statusFifoFull,
    input wire logic faultClear,
    output logic [7:0] dataByte_q,
    output logic dataPush_q,
    output logic [31:0] statusWord_q,
    output logic statusPush_q,
    output logic frameDrop_q,
    output logic receiverHalted_q,
    output logic receiver_halted_pulse_q,
    output logic receive_fault_flag_q
);
    // a watchdog limit outside the allowed window is refused at elaboration
    if (WDOG_BYTES < WDOG_MIN || WDOG_BYTES > WDOG_MAX)
    begin : g_wdog_range
        $error("watchdog limit outside 2048..2560 bytes");
    end

    localparam logic [13:0] WDOG_LIMIT = 14'(WDOG_BYTES);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_SKIP = 5'b00100,
        ST_FINISH = 5'b01000,
        ST_HALT = 5'b10000
    } rxsw_state_e;

    rxsw_state_e state_q;
    logic [13:0] byteCnt_q;
    logic rxErSeen_q;
    logic lateColSeen_q;
    logic wdogHit_q;
    logic crcBad_q;
    logic [2:0] dribble_q;
    logic filterFail_q;
    logic dstBroadcast;
    logic dstMulticast;
    logic [15:0] lenType;
    logic [31:0] statusNext;
    logic runtNow;

    rxsw_hdr_parse u_hdr (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .frameStart(frmStart && state_q == ST_IDLE),
        .byteValid(rxValid && state_q == ST_RECV),
        .byteData(rxByte),
        .dstBroadcast(dstBroadcast),
        .dstMulticast(dstMulticast),
        .lenType(lenType)
    );

    assign runtNow = byteCnt_q < MIN_FRAME;

    always_comb
    begin
        statusNext = STATUS_RESET;
        statusNext[BIT_FILTER_FAIL] = filterFail_q;
        statusNext[LEN_LSB +: LEN_W] = byteCnt_q;
        statusNext[BIT_BCAST] = dstBroadcast;
        statusNext[BIT_LEN_MISMATCH] = !runtNow && lenMismatch(lenType, byteCnt_q);
        statusNext[BIT_RUNT] = runtNow;
        statusNext[BIT_MCAST] = dstMulticast;
        statusNext[BIT_TOO_LONG] = byteCnt_q > MAX_FRAME;
        statusNext[BIT_LATE_COL] = lateColSeen_q;
        statusNext[BIT_FRAME_TYPE] = byteCnt_q >= HDR_BYTES && lenType > MAX_LEN_FIELD;
        statusNext[BIT_WDOG] = wdogHit_q;
        statusNext[BIT_MII_ERR] = rxErSeen_q;
        // leftover bits, suppressed by a late collision
        statusNext[BIT_DRIBBLE] = !lateColSeen_q &&
            (speed10 ? dribble_q >= DRIB_10M : dribble_q == DRIB_MII);
        statusNext[BIT_CRC_ERR] = crcBad_q || rxErSeen_q;
        statusNext[BIT_ERR_SUM] = statusNext[BIT_RUNT] || statusNext[BIT_TOO_LONG] ||
            statusNext[BIT_LATE_COL] || statusNext[BIT_CRC_ERR];
        statusNext[BIT_RSVD31] = 1'b0;
        statusNext[BIT_RSVD14] = 1'b0;
        statusNext[9:8] = 2'b00;
        statusNext[BIT_RSVD0] = 1'b0;
    end

    // a cleared enable lets the current frame finish, then halts
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (!receive_enable_bit)
                    begin
                        state_q <= ST_HALT;
                    end
                    else if (frmStart)
                    begin
                        state_q <= ST_RECV;
                    end
                end
                ST_RECV:
                begin
                    if (frmEnd)
                    begin
                        state_q <= ST_FINISH;
                    end
                    else if (rxValid && byteCnt_q >= WDOG_LIMIT)
                    begin
                        state_q <= ST_SKIP;
                    end
                end
                ST_SKIP:
                begin
                    if (frmEnd)
                    begin
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH:
                begin
                    state_q <= ST_IDLE;
                end
                ST_HALT:
                begin
                    // resume once the host sets the enable again
                    if (receive_enable_bit)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // per-frame counters and sticky frame conditions
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            byteCnt_q <= 14'h0000;
            rxErSeen_q <= 1'b0;
            lateColSeen_q <= 1'b0;
            wdogHit_q <= 1'b0;
            crcBad_q <= 1'b0;
            dribble_q <= 3'h0;
            filterFail_q <= 1'b0;
        end
        else if (state_q == ST_IDLE && frmStart && receive_enable_bit)
        begin
            byteCnt_q <= 14'h0000;
            rxErSeen_q <= rxEr;
            lateColSeen_q <= lateCollision;
            wdogHit_q <= 1'b0;
            crcBad_q <= 1'b0;
            dribble_q <= 3'h0;
            filterFail_q <= 1'b0;
        end
        else if (state_q == ST_RECV || state_q == ST_SKIP)
        begin
            // any receive error during the frame is remembered
            if (rxEr)
            begin
                rxErSeen_q <= 1'b1;
            end
            if (lateCollision)
            begin
                lateColSeen_q <= 1'b1;
            end
            if (rxValid && state_q == ST_RECV)
            begin
                // watchdog stops counting and forwarding at the limit
                if (byteCnt_q >= WDOG_LIMIT)
                begin
                    wdogHit_q <= 1'b1;
                end
                else
                begin
                    byteCnt_q <= byteCnt_q + 14'h0001;
                end
            end
            if (frmEnd)
            begin
                crcBad_q <= crcBad;
                dribble_q <= dribbleBits;
                filterFail_q <= filterFail;
            end
        end
    end

    // data bytes leave before the frame's status word
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            dataByte_q <= 8'h00;
            dataPush_q <= 1'b0;
        end
        else
        begin
            dataPush_q <= state_q == ST_RECV && rxValid && byteCnt_q < WDOG_LIMIT;
            if (state_q == ST_RECV && rxValid)
            begin
                dataByte_q <= rxByte;
            end
        end
    end

    // runts without pass-bad-frames are dropped instead of reported
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            statusWord_q <= STATUS_RESET;
            statusPush_q <= 1'b0;
            frameDrop_q <= 1'b0;
        end
        else
        begin
            statusPush_q <= state_q == ST_FINISH && (!runtNow || passBadFrames);
            frameDrop_q <= state_q == ST_FINISH && runtNow && !passBadFrames;
            if (state_q == ST_FINISH)
            begin
                statusWord_q <= statusNext;
            end
        end
    end

    // single pulse on entry to the halted state
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            receiverHalted_q <= 1'b0;
            receiver_halted_pulse_q <= 1'b0;
        end
        else
        begin
            receiverHalted_q <= state_q == ST_HALT && !receive_enable_bit;
            receiver_halted_pulse_q <= state_q == ST_IDLE && !receive_enable_bit;
        end
    end

    // sticky fault flag; a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            receive_fault_flag_q <= 1'b0;
        end
        else if ((hostDataRead && dataFifoEmpty) || (hostStatusRead && statusFifoEmpty) ||
                 (statusPush_q && statusFifoFull))
        begin
            receive_fault_flag_q <= 1'b1;
        end
        else if (faultClear)
        begin
            receive_fault_flag_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_frame_done;
        state_q == ST_FINISH;
    endsequence

    a_reserved_zero: assert property (
        statusPush_q |-> statusWord_q[31] == 1'b0 && statusWord_q[14] == 1'b0 &&
            statusWord_q[9:8] == 2'b00 && statusWord_q[0] == 1'b0)
        else $error("reserved status bit set");

    a_error_summary: assert property (
        statusPush_q |-> statusWord_q[15] ==
            (statusWord_q[11] | statusWord_q[7] | statusWord_q[6] | statusWord_q[1]))
        else $error("error summary mismatch");

    a_runt_dropped: assert property (
        (s_frame_done ##0 (runtNow && !passBadFrames)) |=> frameDrop_q && !statusPush_q)
        else $error("runt frame not dropped");

    a_runt_passed: assert property (
        (s_frame_done ##0 (runtNow && passBadFrames)) |=> statusPush_q && statusWord_q[11])
        else $error("runt frame not reported");

    a_long_flag: assert property (
        statusPush_q |-> statusWord_q[7] == (statusWord_q[29:16] > MAX_FRAME))
        else $error("frame too long flag wrong");

    a_type_runt14: assert property (
        statusPush_q && statusWord_q[29:16] < HDR_BYTES |-> !statusWord_q[5])
        else $error("frame type set on tiny frame");

    a_dribble_col: assert property (
        statusPush_q && statusWord_q[6] |-> !statusWord_q[2])
        else $error("dribble set with late collision");

    a_rxer_crc: assert property (
        statusPush_q && statusWord_q[3] |-> statusWord_q[1])
        else $error("receive error without crc flag");

    a_halt_pulse: assert property (
        (state_q == ST_IDLE && !receive_enable_bit) |=> receiver_halted_pulse_q ##1 !receiver_halted_pulse_q)
        else $error("halt pulse missing or repeated");

    a_status_last: assert property (
        s_frame_done |=> ((statusPush_q || frameDrop_q) && !dataPush_q) ##1 !dataPush_q)
        else $error("data pushed after status");

    a_fault_set: assert property (
        (hostDataRead && dataFifoEmpty) |=> receive_fault_flag_q)
        else $error("underrun did not raise fault");
endmodule : rxsw_rx_status

// file: rxsw_host_model.sv
// host side model: tracks fifo levels and issues read strobes
`timescale 1ns/1ns
module rxsw_host_model #(
    parameter int DEPTH = 2
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic dataPush_q,
    input wire logic statusPush_q,
    input wire logic autoDrain,
    input wire logic forceDataRead,
    input wire logic forceStatusRead,
    output logic hostDataRead,
    output logic hostStatusRead,
    output logic dataFifoEmpty,
    output logic statusFifoEmpty,
    output logic statusFifoFull
);
    int dataCnt;
    int statCnt;
    logic drainData;
    logic drainStat;

    assign dataFifoEmpty = (dataCnt == 0);
    assign statusFifoEmpty = (statCnt == 0);
    assign statusFifoFull = (statCnt >= DEPTH);
    assign hostDataRead = drainData | forceDataRead;
    assign hostStatusRead = drainStat | forceStatusRead;

    // host drains fifos
    // drain reads only while a level is seen, so draining never underruns
    always @(negedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            drainData <= 1'b0;
            drainStat <= 1'b0;
        end
        else
        begin
            drainData <= autoDrain && dataCnt > 0;
            drainStat <= autoDrain && statCnt > 0;
        end
    end

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            dataCnt <= 0;
            statCnt <= 0;
        end
        else
        begin
            dataCnt <= dataCnt + int'(dataPush_q) - int'(hostDataRead && dataCnt > 0);
            statCnt <= statCnt + int'(statusPush_q && statCnt < DEPTH) - int'(hostStatusRead && statCnt > 0);
        end
    end
endmodule : rxsw_host_model

// file: rxsw_rx_status_tb.sv
// self-checking bench for the receive status word builder
`timescale 1ns/1ns
module rxsw_rx_status_tb
    import rxsw_pkg::*;
();
    localparam int WDOG = 2048;
    logic clk_sys = 1'b0;
    logic nrst, rxEnable, passBad, speed10, frmStart, rxValid, frmEnd, crcBad, rxEr, lateCol, filterFail;
    logic faultClear, autoDrain, forceDataRead, forceStatusRead;
    logic [7:0] rxByte;
    logic [2:0] dribbleBits;
    logic hostDataRead, hostStatusRead, dataFifoEmpty, statusFifoEmpty, statusFifoFull;
    logic [7:0] dataByte_q, lastByte;
    logic dataPush_q, statusPush_q, frameDrop_q, receiverHalted_q, haltPulse_q, fault_q;
    logic [31:0] statusWord_q;
    logic gotStatus, gotDrop;
    int pushCnt, pulses, cycles, miscompares, compares, i, n;
    logic [15:0] lt;

    always #25 clk_sys = ~clk_sys;

    rxsw_rx_status #(.WDOG_BYTES(WDOG)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .receive_enable_bit(rxEnable),
        .passBadFrames(passBad), .speed10(speed10), .frmStart(frmStart), .rxValid(rxValid), .rxByte(rxByte),
        .frmEnd(frmEnd), .crcBad(crcBad), .dribbleBits(dribbleBits), .rxEr(rxEr), .lateCollision(lateCol),
        .filterFail(filterFail), .hostDataRead(hostDataRead), .dataFifoEmpty(dataFifoEmpty),
        .hostStatusRead(hostStatusRead), .statusFifoEmpty(statusFifoEmpty), .statusFifoFull(statusFifoFull),
        .faultClear(faultClear), .dataByte_q(dataByte_q), .dataPush_q(dataPush_q), .statusWord_q(statusWord_q),
        .statusPush_q(statusPush_q), .frameDrop_q(frameDrop_q), .receiverHalted_q(receiverHalted_q),
        .receiver_halted_pulse_q(haltPulse_q), .receive_fault_flag_q(fault_q));

    rxsw_host_model #(.DEPTH(2)) i_host (.clk_sys(clk_sys), .nrst(nrst), .dataPush_q(dataPush_q),
        .statusPush_q(statusPush_q), .autoDrain(autoDrain), .forceDataRead(forceDataRead),
        .forceStatusRead(forceStatusRead), .hostDataRead(hostDataRead), .hostStatusRead(hostStatusRead),
        .dataFifoEmpty(dataFifoEmpty), .statusFifoEmpty(statusFifoEmpty), .statusFifoFull(statusFifoFull));

    always @(posedge clk_sys)
    begin
        cycles++;
        if (dataPush_q === 1'b1)
        begin
            pushCnt++;
            lastByte = dataByte_q;
        end
        if (statusPush_q === 1'b1)
            gotStatus = 1'b1;
        if (frameDrop_q === 1'b1)
            gotDrop = 1'b1;
        if (haltPulse_q === 1'b1)
            pulses++;
        if (cycles >= 30000)
        begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        compares++;
        if (seen !== want)
        begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    function automatic logic [31:0] exp_status(input int n, input int kind, input logic [15:0] lt,
        input logic crc, input logic er, input logic late, input logic [2:0] drib, input logic filt);
        logic [31:0] s;
        int len;
        int pay;
        s = 32'h0000_0000;
        len = (n > WDOG) ? WDOG : n;
        pay = (lt < MIN_PAYLOAD) ? 46 : int'(lt);
        s[30] = filt;
        s[29:16] = len[13:0];
        s[13] = (kind == 1);
        s[12] = (lt <= MAX_LEN_FIELD) && len >= 64 && (len - 18) != pay;
        s[11] = len < 64;
        s[10] = (kind == 2);
        s[7] = len > 1518;
        s[6] = late;
        s[5] = (lt > MAX_LEN_FIELD) && n >= 14;
        s[4] = n > WDOG;
        s[3] = er;
        s[2] = !late && (speed10 ? drib >= DRIB_10M : drib == DRIB_MII);
        s[1] = crc | er;
        s[15] = s[11] | s[7] | s[6] | s[1];
        return s;
    endfunction : exp_status

    task automatic run_frame(input int n, input int kind, input logic [15:0] lt, input logic crc,
        input logic er, input logic late, input logic [2:0] drib, input logic filt);
        logic [7:0] fb [];
        int k;
        int keep;
        fb = new[n];
        for (k = 0; k < n; k++)
            fb[k] = (kind == 1 && k < 6) ? 8'hff : 8'($urandom);
        if (kind != 1)
            fb[0] = (kind == 2) ? 8'h01 : 8'h02;
        if (n > 13)
        begin
            fb[12] = lt[15:8];
            fb[13] = lt[7:0];
        end
        pushCnt = 0;
        gotStatus = 1'b0;
        gotDrop = 1'b0;
        @(negedge clk_sys);
        frmStart = 1'b1;
        rxEr = er;
        lateCol = late;
        for (k = 0; k < n; k++)
        begin
            @(negedge clk_sys);
            frmStart = 1'b0;
            rxValid = 1'b1;
            rxByte = fb[k];
        end
        @(negedge clk_sys);
        rxValid = 1'b0;
        {frmEnd, crcBad, dribbleBits, filterFail} = {1'b1, crc, drib, filt};
        @(negedge clk_sys);
        {frmEnd, rxEr, lateCol} = 3'h0;
        repeat (4) @(negedge clk_sys);
        keep = (n > WDOG) ? WDOG : n;
        if (keep < 64 && !passBad)
            check({gotDrop, gotStatus}, 2'h2, "runt drop");
        else
        begin
            check(statusWord_q, exp_status(n, kind, lt, crc, er, late, drib, filt), "status");
            check(gotStatus, 1'b1, "status push");
            check(pushCnt, keep, "byte count");
            check(lastByte, fb[keep-1], "last byte");
        end
    endtask : run_frame

    initial
    begin
        {nrst, passBad, speed10, frmStart, rxValid, frmEnd, crcBad, rxEr, lateCol, filterFail} = 10'h000;
        {faultClear, forceDataRead, forceStatusRead, rxByte, dribbleBits} = 14'h0000;
        {rxEnable, autoDrain} = 2'h3;
        {cycles, miscompares, compares, pushCnt, pulses} = 160'h0;
        void'($urandom(32'h5540));
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
        for (i = 0; i < 6; i++)
        begin
            n = 64 + $urandom % 1455;
            case ($urandom % 3)
                0: lt = 16'h0600 + 16'($urandom % 4096);
                1: lt = 16'(n - 18);
                default: lt = 16'($urandom % 1501);
            endcase
            speed10 = 1'($urandom);
            run_frame(n, $urandom % 3, lt, 1'($urandom), ($urandom % 4) == 0, ($urandom % 4) == 0,
                3'($urandom), 1'($urandom));
        end
        run_frame(40, 0, 16'h0800, 0, 0, 0, 3'h0, 0);
        passBad = 1'b1;
        run_frame(40, 1, 16'h0800, 0, 0, 0, 3'h0, 0);
        run_frame(10, 0, 16'h0800, 0, 0, 0, 3'h0, 0);
        run_frame(1600, 2, 16'h0800, 0, 0, 0, 3'h0, 0);
        run_frame(2100, 0, 16'h0800, 0, 0, 0, 3'h0, 0);
        run_frame(64, 0, 16'h001e, 0, 0, 1, 3'h4, 0);
        speed10 = 1'b0;
        run_frame(100, 0, 16'h0052, 0, 0, 0, 3'h3, 0);
        speed10 = 1'b1;
        run_frame(100, 1, 16'h0010, 0, 0, 0, 3'h3, 0);
        run_frame(80, 2, 16'h0800, 0, 1, 0, 3'h0, 1);
        pulses = 0;
        rxEnable = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(pulses, 1, "halt pulse");
        check(receiverHalted_q, 1'b1, "halted");
        rxEnable = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(receiverHalted_q, 1'b0, "resumed");
        autoDrain = 1'b0;
        repeat (10) @(negedge clk_sys);
        for (i = 0; i < 2; i++)
        begin
            {forceStatusRead, forceDataRead} = (i == 0) ? 2'h1 : 2'h2;
            @(negedge clk_sys);
            {forceStatusRead, forceDataRead} = 2'h0;
            @(negedge clk_sys);
            check(fault_q, 1'b1, "underrun flag");
            faultClear = 1'b1;
            @(negedge clk_sys);
            faultClear = 1'b0;
            @(negedge clk_sys);
            check(fault_q, 1'b0, "flag cleared");
        end
        // one more underrun, then the soft reset that realigns the host
        forceDataRead = 1'b1;
        @(negedge clk_sys);
        forceDataRead = 1'b0;
        check(fault_q, 1'b1, "underrun again");
        nrst = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({fault_q, statusPush_q, dataPush_q, haltPulse_q, receiverHalted_q}, 5'h00, "soft reset");
        nrst = 1'b1;
        run_frame(64, 0, 16'h0800, 0, 0, 0, 3'h0, 0);
        run_frame(64, 0, 16'h0800, 0, 0, 0, 3'h0, 0);
        check(fault_q, 1'b0, "no overrun yet");
        run_frame(64, 0, 16'h0800, 0, 0, 0, 3'h0, 0);
        check(fault_q, 1'b1, "overrun flag");
        finish_test();
    end
endmodule : rxsw_rx_status_tb
